// File: mtc_pkg.sv
package mtc_pkg;
	localparam int WORD_W = 16;
	localparam int TNUM_W = 9;
	localparam logic [1:0] OFS_COPY_SRC = 2'h1;
	localparam logic [1:0] OFS_COPY_TYPE_DST = 2'h2;
	localparam logic [1:0] OFS_INDIRECT = 2'h3;
	localparam int BCD_W = 12;
	localparam int TYPE_LSB = 12;
	localparam logic [3:0] COPY_TYPE_CHAR = 4'h0;
	localparam logic [3:0] COPY_TYPE_NUM = 4'h1;
	localparam logic [3:0] COPY_TYPE_IDLE = 4'hF;
	localparam logic [9:0] NUM_TABLE_MAX = 10'h1FF;
	localparam logic [9:0] CHAR_TABLE_MAX = 10'h0FF;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'hF000;
	localparam int POLL_CYCLES = 4;
endpackage

// File: mtc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mtc_link_if;
	logic        wr;
	logic [1:0]  addr;
	logic [15:0] wdata;
	modport host_end (output wr, output addr, output wdata);
	modport term_end (input wr, input addr, input wdata);
endinterface
`default_nettype wire

// File: mtc_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mtc_host_ctrl (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	mtc_link_if.host_end     link,
	input  wire logic [1:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	// Avalon regs: 0 copy order {type,dst,src}, 1 indirect number, 2 status
	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_KILL = 3'b001, H_SRC = 3'b011, H_DST = 3'b010, H_IND = 3'b100
	} hstate_t;
	typedef struct packed {
		hstate_t     st;
		logic [3:0]  ctype;
		logic [11:0] dst;
		logic [11:0] src;
		logic [15:0] ind;
		logic [31:0] rdata;
		logic        wait_n;
		logic        busy;
		logic [3:0]  hold;
		logic        wr;
		logic [1:0]  addr;
		logic [15:0] wdata;
	} hstate_all_t;
	hstate_all_t q, d;
	assign link.wr = q.wr;
	assign link.addr = q.addr;
	assign link.wdata = q.wdata;
	assign o_avs_readdata = q.rdata;
	assign o_avs_waitrequest = ~q.wait_n;
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.wait_n = 1'b0;
		case (q.st)
			H_IDLE: begin
				if ((i_avs_read || i_avs_write) && !q.wait_n) begin
					d.wait_n = 1'b1;
					if (i_avs_write && i_avs_address == 2'h0) begin
						d.ctype = i_avs_writedata[27:24];
						d.dst = i_avs_writedata[23:12];
						d.src = i_avs_writedata[11:0];
						d.busy = 1'b1;
						d.st = H_KILL;
					end else if (i_avs_write && i_avs_address == 2'h1) begin
						d.ind = i_avs_writedata[15:0];
						d.busy = 1'b1;
						d.st = H_IND;
					end
					d.rdata = (i_avs_address == 2'h0) ? {4'h0, q.ctype, q.dst, q.src} :
						(i_avs_address == 2'h1) ? {16'h0000, q.ind} :
						(i_avs_address == 2'h2) ? {31'h0, q.busy} : 32'h0000_0000;
				end
			end
			H_KILL: begin
				// Invalid type first so a repeated order still reads as a change
				d.wr = 1'b1;
				d.addr = mtc_pkg::OFS_COPY_TYPE_DST;
				d.wdata = {mtc_pkg::COPY_TYPE_IDLE, q.dst};
				d.hold = 4'(mtc_pkg::POLL_CYCLES);
				d.st = H_SRC;
			end
			H_SRC: begin
				// Destination went out with the kill word, source follows
				d.wr = 1'b1;
				d.addr = mtc_pkg::OFS_COPY_SRC;
				d.wdata = {4'h0, q.src};
				d.st = H_DST;
			end
			H_DST: begin
				// Idle type must stand a full poll period or the terminal may miss it
				if (q.hold != 4'h0) begin
					d.hold = q.hold - 4'h1;
				end else begin
					d.wr = 1'b1; // Valid type last, so a half-written order never copies
					d.addr = mtc_pkg::OFS_COPY_TYPE_DST;
					d.wdata = {q.ctype, q.dst};
					d.busy = 1'b0;
					d.st = H_IDLE;
				end
			end
			H_IND: begin
				d.wr = 1'b1; // Single word indirect reference
				d.addr = mtc_pkg::OFS_INDIRECT;
				d.wdata = q.ind;
				d.busy = 1'b0;
				d.st = H_IDLE;
			end
			default: d.st = H_IDLE;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
			q.ctype <= mtc_pkg::COPY_TYPE_IDLE;
		end else begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// File: mtc_terminal.sv
`timescale 1ns/1ps
`default_nettype none
module mtc_terminal #(
	parameter int NUM_TABLES = 512,
	parameter int CHAR_TABLES = 256
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	mtc_link_if.term_end     link,
	input  wire logic        i_show_char,
	input  wire logic [8:0]  i_tbl_addr,
	input  wire logic [15:0] i_tbl_wdata,
	input  wire logic        i_tbl_we_num,
	input  wire logic        i_tbl_we_char,
	output logic [15:0]      o_disp_data,
	output logic [8:0]       o_disp_table,
	output logic             o_disp_refresh,
	output logic             o_copy_done,
	output logic             o_copy_rejected
);
	// Table numbers are 9 and 8 bits wide; other counts would alias
	if (NUM_TABLES != 512 || CHAR_TABLES != 256) begin
		$error("table counts must be 512 and 256");
	end
	typedef enum logic [1:0] {
		T_RUN = 2'b00, T_READ = 2'b01, T_WRITE = 2'b11
	} tstate_t;
	typedef struct packed {
		tstate_t     st;
		logic [15:0] w_src;
		logic [15:0] w_tdst;
		logic [15:0] w_ind;
		logic [15:0] s_src;
		logic [15:0] s_tdst;
		logic [15:0] p_src;
		logic [15:0] p_tdst;
		logic [1:0]  poll;
		logic        cp_char;
		logic [8:0]  cp_src;
		logic [8:0]  cp_dst;
		logic [15:0] cp_data;
		logic [8:0]  disp_tbl;
		logic [15:0] disp_data;
		logic        rd_ok;
		logic [8:0]  rd_tbl;
		logic        refresh;
		logic        done;
		logic        rejected;
	} tstate_all_t;
	tstate_all_t q, d;
	logic [15:0] num_mem [NUM_TABLES];
	logic [15:0] char_mem [CHAR_TABLES];
	logic [15:0] rd_num, rd_char;
	logic        mem_we_num, mem_we_char;
	logic [8:0]  mem_addr;
	logic [15:0] mem_wdata;

	// Three BCD digits, checked for digit range and table limit
	function automatic logic bcd_ok(input logic [11:0] v, input logic [9:0] lim);
		logic [9:0] bin;
		bin = 10'(v[11:8]) * 10'd100 + 10'(v[7:4]) * 10'd10 + 10'(v[3:0]);
		return (v[11:8] < 4'hA) && (v[7:4] < 4'hA) && (v[3:0] < 4'hA) && (bin <= lim);
	endfunction
	function automatic logic [8:0] bcd_bin(input logic [11:0] v);
		logic [9:0] bin;
		bin = 10'(v[11:8]) * 10'd100 + 10'(v[7:4]) * 10'd10 + 10'(v[3:0]);
		return bin[8:0];
	endfunction

	// Preload and copy words land in the numeral and character tables
	always_ff @(posedge i_core_clk) begin
		rd_num <= num_mem[mem_addr];
		rd_char <= char_mem[mem_addr[7:0]];
		if (mem_we_num)
			num_mem[mem_addr] <= mem_wdata;
		if (mem_we_char)
			char_mem[mem_addr[7:0]] <= mem_wdata;
	end

	always_comb begin
		logic [3:0]  ctype;
		logic [9:0]  lim;
		logic        ind_char_ok;
		d = q;
		ctype = q.s_tdst[15:12];
		lim = 10'h000;
		ind_char_ok = 1'b0;
		d.refresh = 1'b0;
		d.done = 1'b0;
		d.rejected = 1'b0;
		d.rd_ok = 1'b0;
		mem_we_num = i_tbl_we_num;
		mem_we_char = i_tbl_we_char;
		mem_addr = i_tbl_addr;
		mem_wdata = i_tbl_wdata;
		if (link.wr) begin
			case (link.addr)
				mtc_pkg::OFS_COPY_SRC: d.w_src = link.wdata;
				mtc_pkg::OFS_COPY_TYPE_DST: d.w_tdst = link.wdata;
				mtc_pkg::OFS_INDIRECT: d.w_ind = link.wdata;
				default: ;
			endcase
		end
		// Indirect word must be plain BCD with a zero top digit
		ind_char_ok = bcd_ok(q.w_ind[11:0], i_show_char ? mtc_pkg::CHAR_TABLE_MAX
			: mtc_pkg::NUM_TABLE_MAX) && (q.w_ind[15:12] == 4'h0);
		case (q.st)
			T_RUN: begin
				// Word value names the shown table; bad numbers hold display
				if (ind_char_ok && bcd_bin(q.w_ind[11:0]) != q.disp_tbl) begin
					d.disp_tbl = bcd_bin(q.w_ind[11:0]);
					d.refresh = 1'b1;
				end
				// Fetch only the table on display; a preload owns the port
				if (!i_tbl_we_num && !i_tbl_we_char) begin
					mem_addr = q.disp_tbl;
					d.rd_ok = 1'b1;
					d.rd_tbl = q.disp_tbl;
				end
				// Read data lags its address a cycle; use it only if it matches
				if (q.rd_ok && q.rd_tbl == q.disp_tbl)
					d.disp_data = i_show_char ? rd_char : rd_num;
				// Words are taken whenever the count wraps, mid-write or not
				d.poll = q.poll + 2'd1;
				if (q.poll == 2'(mtc_pkg::POLL_CYCLES - 1)) begin
					d.s_src = q.w_src;
					d.s_tdst = q.w_tdst;
				end
				// One request per change of the sampled pair
				if (q.s_src != q.p_src || q.s_tdst != q.p_tdst) begin
					d.p_src = q.s_src;
					d.p_tdst = q.s_tdst;
					lim = (ctype == mtc_pkg::COPY_TYPE_NUM) ? mtc_pkg::NUM_TABLE_MAX
						: mtc_pkg::CHAR_TABLE_MAX;
					if ((ctype == mtc_pkg::COPY_TYPE_CHAR || ctype == mtc_pkg::COPY_TYPE_NUM)
						&& bcd_ok(q.s_src[11:0], lim) && bcd_ok(q.s_tdst[11:0], lim)) begin
						d.cp_char = (ctype == mtc_pkg::COPY_TYPE_CHAR);
						d.cp_src = bcd_bin(q.s_src[11:0]);
						d.cp_dst = bcd_bin(q.s_tdst[11:0]);
						d.st = T_READ;
					end else if (ctype == mtc_pkg::COPY_TYPE_CHAR || ctype == mtc_pkg::COPY_TYPE_NUM) begin
						// Valid type with a bad number is flagged, never copied
						d.rejected = 1'b1;
					end // Other types do nothing
				end
			end
			T_READ: begin
				// Preload is locked out for the two copy cycles
				mem_we_num = 1'b0;
				mem_we_char = 1'b0;
				mem_addr = q.cp_src;
				d.st = T_WRITE;
			end
			T_WRITE: begin
				// Source into destination, refresh if shown
				mem_we_num = !q.cp_char;
				mem_we_char = q.cp_char;
				mem_addr = q.cp_dst;
				mem_wdata = q.cp_char ? rd_char : rd_num;
				d.done = 1'b1;
				if (q.cp_dst == q.disp_tbl && q.cp_char == i_show_char) begin
					d.disp_data = mem_wdata;
					d.refresh = 1'b1;
				end
				d.st = T_RUN;
			end
			default: d.st = T_RUN;
		endcase
	end

	assign o_disp_data = q.disp_data;
	assign o_disp_table = q.disp_tbl;
	assign o_disp_refresh = q.refresh;
	assign o_copy_done = q.done;
	assign o_copy_rejected = q.rejected;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
			q.w_tdst <= mtc_pkg::CMD_RESET;
			q.s_tdst <= mtc_pkg::CMD_RESET;
			q.p_tdst <= mtc_pkg::CMD_RESET;
		end else begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// File: mtc_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mtc_link_monitor (
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        wr,
	input wire logic [1:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        i_show_char,
	input wire logic [8:0]  o_disp_table,
	input wire logic        o_disp_refresh,
	input wire logic        o_copy_done,
	input wire logic        o_copy_rejected
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	logic [9:0] ival;
	logic       iok;
	assign ival = 10'(wdata[11:8]) * 10'h064 + 10'(wdata[7:4]) * 10'h00A + 10'(wdata[3:0]);
	assign iok = wdata[15:12] == 4'h0 && wdata[11:8] <= 4'h9 && wdata[7:4] <= 4'h9
		&& wdata[3:0] <= 4'h9 && ival <= (i_show_char ? 10'h0FF : 10'h1FF);
	logic [1:0] stage_q;
	logic [3:0] last_type_q;
	// Host order: kill word, then source, then the valid type
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage_q <= 2'h0;
			last_type_q <= 4'hF;
		end else if (wr && addr == 2'h2) begin
			stage_q <= (wdata[15:12] == 4'hF) ? 2'h1 : 2'h0;
			last_type_q <= wdata[15:12];
		end else if (wr && addr == 2'h1 && stage_q == 2'h1) begin
			stage_q <= 2'h2;
		end
	end
	a_ind_select: assert property (wr && addr == 2'h3 && iok |-> ##2
		o_disp_table == $past(ival[8:0], 2)) else $error("indirect select");
	a_ind_refresh: assert property (wr && addr == 2'h3 && iok && ival[8:0] != o_disp_table |->
		##2 o_disp_refresh) else $error("indirect change without refresh");
	a_ind_bad_hold: assert property (wr && addr == 2'h3 && !iok |-> ##2
		$stable(o_disp_table)) else $error("bad indirect moved display");
	a_dst_first: assert property (wr && addr == 2'h1 |->
		stage_q == 2'h1) else $error("source before destination");
	a_idle_first: assert property (wr && addr == 2'h2 && wdata[15:12] != 4'hF |->
		stage_q == 2'h2) else $error("no idle type first");
	a_done_type: assert property (o_copy_done |-> last_type_q <= 4'h1)
		else $error("copy with other type");
	a_src_top_zero: assert property (wr && addr == 2'h1 |->
		wdata[15:12] == 4'h0) else $error("source top digit");
	a_addr_used: assert property (wr |-> addr != 2'h0) else $error("write to offset 0");
	a_one_copy: assert property (o_copy_done |=> !o_copy_done [*3])
		else $error("copy repeated");
	a_done_or_rej: assert property (!(o_copy_done && o_copy_rejected))
		else $error("done with rejected");
	cover property (o_copy_done);
	cover property (o_copy_rejected);
	cover property (wr && addr == 2'h3 && iok);
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk;
	logic        nrst;
	logic [1:0]  av_a;
	logic        av_rd;
	logic        av_wr;
	logic [31:0] av_wd;
	logic [31:0] av_q;
	logic        av_wait;
	logic        show_char;
	logic [8:0]  tbl_a;
	logic [15:0] tbl_d;
	logic        we_num;
	logic        we_char;
	logic [15:0] disp_data;
	logic [8:0]  disp_table;
	logic        refresh;
	logic        done;
	logic        rej;
	logic [31:0] q;
	logic [15:0] done_n;
	logic [15:0] rej_n;
	int          mismatches;
	int          compares;
	int          cyc;
	mtc_link_if link_if();
	mtc_host_ctrl mtc_host_ctrl_inst (.i_core_clk(clk), .i_nrst(nrst), .link(link_if.host_end),
		.i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
		.o_avs_readdata(av_q), .o_avs_waitrequest(av_wait));
	mtc_terminal mtc_terminal_inst (.i_core_clk(clk), .i_nrst(nrst), .link(link_if.term_end),
		.i_show_char(show_char), .i_tbl_addr(tbl_a), .i_tbl_wdata(tbl_d), .i_tbl_we_num(we_num),
		.i_tbl_we_char(we_char), .o_disp_data(disp_data), .o_disp_table(disp_table),
		.o_disp_refresh(refresh), .o_copy_done(done), .o_copy_rejected(rej));
	mtc_link_monitor mtc_link_monitor_inst (.i_core_clk(clk), .i_nrst(nrst), .wr(link_if.wr),
		.addr(link_if.addr), .wdata(link_if.wdata), .i_show_char(show_char),
		.o_disp_table(disp_table), .o_disp_refresh(refresh), .o_copy_done(done),
		.o_copy_rejected(rej));
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Held until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		av_a <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wd <= d;
		do @(posedge clk); while (av_wait !== 1'b0);
		q = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	// Busy poll keeps a new order off the link until the last one is out
	task automatic cmd(input logic [3:0] t, input logic [11:0] dst, input logic [11:0] src);
		av(1'b1, 2'h0, {4'h0, t, dst, src});
		q = 32'h1;
		while (q[0] !== 1'b0)
			av(1'b0, 2'h2, 32'h0);
		repeat (12) @(posedge clk);
	endtask
	task automatic ind(input logic [15:0] v);
		av(1'b1, 2'h1, {16'h0, v});
		repeat (4) @(posedge clk);
	endtask
	task automatic ld(input logic c, input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		tbl_a <= a;
		tbl_d <= d;
		we_num <= !c;
		we_char <= c;
		@(posedge clk);
		we_num <= 1'b0;
		we_char <= 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pulses are seen once each, at the edge that ends them
	always @(posedge clk) begin
		cyc++;
		if (!nrst) begin
			done_n <= 16'h0000;
			rej_n <= 16'h0000;
		end else begin
			if (done === 1'b1)
				done_n <= done_n + 16'h0001;
			if (rej === 1'b1)
				rej_n <= rej_n + 16'h0001;
		end
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		nrst = 1'b0;
		{av_a, av_rd, av_wr, av_wd, show_char, tbl_a, tbl_d, we_num, we_char} = '0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		ld(1'b0, 9'h005, 16'h1234);
		ld(1'b1, 9'h003, 16'hABCD);
		ind(16'h0007);
		chk("disp_table", 16'h0007, {7'h0, disp_table});
		cmd(4'h1, 12'h007, 12'h005);
		chk("disp_data", 16'h1234, disp_data);
		chk("copies", 16'h0001, done_n);
		repeat (40) @(posedge clk);
		chk("copies", 16'h0001, done_n);
		$display("test numeral copy done");
		show_char <= 1'b1;
		ind(16'h0255);
		chk("disp_table", 16'h00FF, {7'h0, disp_table});
		ind(16'h0256);
		chk("disp_table", 16'h00FF, {7'h0, disp_table});
		ind(16'h00A1);
		chk("disp_table", 16'h00FF, {7'h0, disp_table});
		ind(16'h0009);
		cmd(4'h0, 12'h009, 12'h003);
		chk("disp_data", 16'hABCD, disp_data);
		$display("test char copy done");
		cmd(4'h1, 12'h512, 12'h005);
		chk("rejects", 16'h0001, rej_n);
		cmd(4'h0, 12'h256, 12'h003);
		chk("rejects", 16'h0002, rej_n);
		for (int t = 2; t < 15; t++)
			cmd(4'(t), 12'h009, 12'h005);
		chk("copies", 16'h0002, done_n);
		chk("rejects", 16'h0002, rej_n);
		$display("test bad copies done");
		show_char <= 1'b0;
		ind(16'h0511);
		chk("disp_table", 16'h01FF, {7'h0, disp_table});
		ind(16'h0512);
		chk("disp_table", 16'h01FF, {7'h0, disp_table});
		cmd(4'h1, 12'h511, 12'h005);
		chk("disp_data", 16'h1234, disp_data);
		$display("test bounds done");
		ld(1'b0, 9'h005, 16'h5678);
		cmd(4'h1, 12'h511, 12'h005);
		chk("disp_data", 16'h5678, disp_data);
		chk("copies", 16'h0004, done_n);
		av(1'b0, 2'h0, 32'h0000_0000);
		chk("order_hi", 16'h0151, q[31:16]);
		chk("order_lo", 16'h1005, q[15:0]);
		$display("test repeat copy done");
		end_sim();
	end
endmodule
`default_nettype wire
